// ==== pkg/mic_pkg.sv ====
// Package of constants and types for the microcontroller interrupt controller.
package mic_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_IRQ_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_EDGE_OPTION = 4'h1;
   localparam logic [3:0] ADDR_EEPROM_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_PORT_FLAG = 0;
   localparam int BIT_EXT_FLAG = 1;
   localparam int BIT_TMR_FLAG = 2;
   localparam int BIT_PORT_EN = 3;
   localparam int BIT_EXT_EN = 4;
   localparam int BIT_TMR_EN = 5;
   localparam int BIT_EE_EN = 6;
   localparam int BIT_GIE = 7;
   localparam int BIT_EDGE_SEL = 6;
   localparam int BIT_EE_FLAG = 4;
   localparam int PORT_HI = 7;
   localparam int PORT_LO = 4;
   // ---------------------------------------------------------------
   // Reset values and constants
   // ---------------------------------------------------------------
   localparam logic [7:0] RESET_IRQ_CONTROL = 8'h00;
   localparam logic [7:0] RESET_EDGE_OPTION = 8'hff;
   localparam logic [7:0] RESET_EEPROM_CONTROL = 8'h00;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   localparam logic [1:0] ENTRY_CYCLES = 2'h2;
   // ---------------------------------------------------------------
   // States of the request sequencer
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MIC_RUN = 3'b001,
      MIC_WAIT = 3'b010,
      MIC_ENTRY = 3'b100
   } mic_state_t;
endpackage

// ==== src/mic_interrupt_controller.sv ====
// Interrupt controller with flag, enable, wake and vector request logic.
//
// Summary of operation
// - Four sources: pin, timer, port change, EEPROM.
// - Bit 7 global enable gates all requests.
// - Reset clears the global enable.
// - Return from interrupt sets global enable.
// - Entry clears enable, pushes, vectors 0004h.
// - Pin event to vector in three-four cycles; here at least six core_clk cycles from pin change to pc_load.
// - Flags set regardless of any enable.
// - Pin edge chosen by edge-select bit 6.
// - Pin edge sets bit 1, bit 4 enables.
// - Pin wakes sleep only when enabled beforehand; here a pending pin flag also wakes once bit 4 is set during sleep.
// - Timer rollover sets bit 2, bit 5 enables.
// - Port 7:4 change sets bit 0, bit 3 enables.
// - EEPROM done sets flag, bit 6 enables.
// - Hardware saves only return address.
// - Enabled pin, port or EEPROM source wakes regardless of global enable; timer cannot wake.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module mic_interrupt_controller (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Event sources
   input wire logic ext_irq_pin,
   input wire logic [3:0] second_io_port_hi,
   input wire logic timer_zero_rollover,
   input wire logic eeprom_write_done,
   // Core sequencer
   input wire logic cycle_boundary,
   input wire logic return_from_irq,
   input wire logic sleep_active,
   input wire logic [12:0] return_pc,
   output logic irq_request,
   output logic stack_push,
   output logic [12:0] stack_push_data,
   output logic pc_load,
   output logic [12:0] pc_load_value,
   output logic wake_up
);
   import mic_pkg::*;

   // ---------------------------------------------------------------
   // Registers and internal state
   // ---------------------------------------------------------------
   logic [7:0] irq_control_reg;
   logic [7:0] edge_option;
   logic eeprom_done_flag;
   logic ext_pin_sync1;
   logic ext_pin_sync2;
   logic ext_pin_prev;
   logic [3:0] port_sync1;
   logic [3:0] port_sync2;
   logic [3:0] port_prev;
   logic ext_event;
   logic port_event;
   logic pending;
   logic sleep_pending;
   logic write_ctl;
   logic write_ee;
   logic write_opt;
   logic entry_start;
   logic ext_req;
   logic tmr_req;
   logic port_req;
   logic ee_req;
   logic [1:0] entry_count;
   mic_state_t state;
   mic_state_t next_state;

   function automatic logic gated(input logic flag, input logic enable);
      gated = flag & enable;
   endfunction

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ext_pin_sync1 <= 1'b0;
         ext_pin_sync2 <= 1'b0;
         ext_pin_prev <= 1'b0;
      end else begin
         ext_pin_sync1 <= ext_irq_pin;
         ext_pin_sync2 <= ext_pin_sync1;
         ext_pin_prev <= ext_pin_sync2;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         port_sync1 <= 4'h0;
         port_sync2 <= 4'h0;
         port_prev <= 4'h0;
      end else begin
         port_sync1 <= second_io_port_hi;
         port_sync2 <= port_sync1;
         port_prev <= port_sync2;
      end
   end

   // ---------------------------------------------------------------
   // Event detection
   // ---------------------------------------------------------------
   always_comb begin
      // Rising edge when edge select is set, falling edge otherwise.
      if (edge_option[BIT_EDGE_SEL]) begin
         ext_event = ext_pin_sync2 & ~ext_pin_prev;
      end else begin
         ext_event = ~ext_pin_sync2 & ext_pin_prev;
      end
      // A level held one cycle passes the synchroniser and is compared.
      port_event = |(port_sync2 ^ port_prev);
   end

   assign write_ctl = reg_write && (reg_addr == ADDR_IRQ_CONTROL);
   assign write_ee = reg_write && (reg_addr == ADDR_EEPROM_CONTROL);
   assign write_opt = reg_write && (reg_addr == ADDR_EDGE_OPTION);

   // ---------------------------------------------------------------
   // Entry strobe
   // ---------------------------------------------------------------
   // First cycle of entry clears the enable, pushes and vectors.
   assign entry_start = (state == MIC_ENTRY) && (entry_count == 2'h0);

   // ---------------------------------------------------------------
   // Interrupt control register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_control_reg <= RESET_IRQ_CONTROL;
      end else begin
         if (write_ctl) begin
            irq_control_reg <= reg_wdata;
         end
         if (return_from_irq) begin
            irq_control_reg[BIT_GIE] <= 1'b1;
         end
         if (entry_start) begin
            irq_control_reg[BIT_GIE] <= 1'b0;
         end
         // Hardware sets win over a software clear in the same cycle.
         if (ext_event) begin
            irq_control_reg[BIT_EXT_FLAG] <= 1'b1;
         end
         if (timer_zero_rollover) begin
            irq_control_reg[BIT_TMR_FLAG] <= 1'b1;
         end
         if (port_event) begin
            irq_control_reg[BIT_PORT_FLAG] <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Option and EEPROM control registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         edge_option <= RESET_EDGE_OPTION;
      end else if (write_opt) begin
         edge_option <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         eeprom_done_flag <= RESET_EEPROM_CONTROL[BIT_EE_FLAG];
      end else if (eeprom_write_done) begin
         eeprom_done_flag <= 1'b1;
      end else if (write_ee) begin
         eeprom_done_flag <= reg_wdata[BIT_EE_FLAG];
      end
   end

   // ---------------------------------------------------------------
   // Pending source detection
   // ---------------------------------------------------------------
   assign ext_req = gated(irq_control_reg[BIT_EXT_FLAG], irq_control_reg[BIT_EXT_EN]);
   assign tmr_req = gated(irq_control_reg[BIT_TMR_FLAG], irq_control_reg[BIT_TMR_EN]);
   assign port_req = gated(irq_control_reg[BIT_PORT_FLAG], irq_control_reg[BIT_PORT_EN]);
   assign ee_req = gated(eeprom_done_flag, irq_control_reg[BIT_EE_EN]);

   always_comb begin
      pending = ext_req | tmr_req | port_req | ee_req;
      // Peripherals without clocks in sleep: timer cannot wake.
      sleep_pending = ext_req | port_req | ee_req;
   end

   // ---------------------------------------------------------------
   // Request sequencer
   // ---------------------------------------------------------------
   // A request waits until the core is awake and at a boundary.
   always_comb begin
      case (state)
         MIC_RUN: begin
            if (pending && irq_control_reg[BIT_GIE]) begin
               next_state = MIC_WAIT;
            end else begin
               next_state = MIC_RUN;
            end
         end
         MIC_WAIT: begin
            if (!irq_control_reg[BIT_GIE] || !pending) begin
               next_state = MIC_RUN;
            end else if (cycle_boundary && !sleep_active) begin
               next_state = MIC_ENTRY;
            end else begin
               next_state = MIC_WAIT;
            end
         end
         MIC_ENTRY: begin
            if (entry_count == ENTRY_CYCLES) begin
               next_state = MIC_RUN;
            end else begin
               next_state = MIC_ENTRY;
            end
         end
         default: begin
            next_state = MIC_RUN;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= MIC_RUN;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         entry_count <= 2'h0;
      end else if (state == MIC_ENTRY) begin
         entry_count <= entry_count + 2'h1;
      end else begin
         entry_count <= 2'h0;
      end
   end

   // ---------------------------------------------------------------
   // Core outputs
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_request <= 1'b0;
      end else begin
         irq_request <= (next_state != MIC_RUN);
      end
   end

   // Only the return address is saved; context is software's job.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         stack_push <= 1'b0;
      end else begin
         stack_push <= entry_start;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         stack_push_data <= 13'h0000;
      end else begin
         stack_push_data <= return_pc;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pc_load <= 1'b0;
      end else begin
         pc_load <= entry_start;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pc_load_value <= 13'h0000;
      end else begin
         pc_load_value <= IRQ_VECTOR;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         wake_up <= 1'b0;
      end else begin
         wake_up <= sleep_active && sleep_pending;
      end
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   // Unmapped indices read zero, and data stand one cycle only.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         case (reg_addr)
            ADDR_IRQ_CONTROL: begin
               reg_rdata <= irq_control_reg;
            end
            ADDR_EDGE_OPTION: begin
               reg_rdata <= edge_option;
            end
            ADDR_EEPROM_CONTROL: begin
               reg_rdata <= {3'h0, eeprom_done_flag, 4'h0};
            end
            ADDR_STATUS: begin
               reg_rdata <= {5'h00, state};
            end
            default: begin
               reg_rdata <= 8'h00;
            end
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// ==== verif/mic_core_model.sv ====
// Core sequencer model giving instruction boundaries and return addresses.
`timescale 1ns/1ps
module mic_core_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Bench control
   input wire logic slow,
   // Controller side
   input wire logic irq_request,
   output logic cycle_boundary,
   output logic [12:0] return_pc
);
   logic phase;
   // Boundaries every cycle, or every second cycle for two-cycle instructions.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         phase <= 1'b0;
      end else begin
         phase <= ~phase;
      end
   end
   assign cycle_boundary = !slow || phase;
   // The program counter halts while a request is being entered.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         return_pc <= 13'h0100;
      end else if (cycle_boundary && !irq_request) begin
         return_pc <= return_pc + 13'h0001;
      end
   end
endmodule

// ==== verif/mic_interrupt_controller_monitor.sv ====
// Checker of the interrupt controller port behaviour.
`timescale 1ns/1ps
module mic_interrupt_controller_monitor (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Observed ports
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic sleep_active,
   input wire logic [12:0] return_pc,
   input wire logic irq_request,
   input wire logic stack_push,
   input wire logic [12:0] stack_push_data,
   input wire logic pc_load,
   input wire logic [12:0] pc_load_value,
   input wire logic wake_up
);
   import mic_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   a_push_with_load: assert property (stack_push |-> pc_load)
      else $error("push without load");
   a_push_single: assert property (stack_push |=> !stack_push)
      else $error("push longer than one cycle");
   a_push_needs_req: assert property (stack_push |-> $past(irq_request))
      else $error("push without request");
   a_vector_value: assert property (pc_load |-> pc_load_value == IRQ_VECTOR)
      else $error("wrong vector");
   a_pushed_pc: assert property (stack_push |-> stack_push_data == return_pc)
      else $error("wrong pushed address");
   a_request_drops: assert property (stack_push |-> ##[0:4] !irq_request)
      else $error("request held after entry");
   a_reset_quiet: assert property (disable iff (1'b0)
      reset |=> !irq_request && !stack_push && !wake_up)
      else $error("outputs active after reset");
   a_read_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_wake_sleep: assert property (wake_up |-> $past(sleep_active))
      else $error("wake while awake");
endmodule
bind mic_interrupt_controller mic_interrupt_controller_monitor u_mic_interrupt_controller_monitor (
   .core_clk(core_clk), .reset(reset), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .sleep_active(sleep_active), .return_pc(return_pc), .irq_request(irq_request),
   .stack_push(stack_push), .stack_push_data(stack_push_data), .pc_load(pc_load),
   .pc_load_value(pc_load_value), .wake_up(wake_up));

// ==== verif/mic_interrupt_controller_tb_top.sv ====
// Self-checking testbench of the interrupt controller.
`timescale 1ns/1ps
module mic_interrupt_controller_tb_top;
   import mic_pkg::*;
   logic core_clk = 0, reset = 1, reg_write = 0, reg_read = 0, ext_irq_pin = 0, slow = 0;
   logic timer_zero_rollover = 0, eeprom_write_done = 0, return_from_irq = 0, sleep_active = 1;
   logic [3:0] reg_addr = 0, second_io_port_hi = 0;
   logic [7:0] reg_wdata = 0, reg_rdata, en, sel;
   logic cycle_boundary, irq_request, stack_push, pc_load, wake_up;
   logic [12:0] return_pc, stack_push_data, pc_load_value;
   int miscompares = 0, samples_checked = 0, i, k, src;
   always #10 core_clk = ~core_clk;
   mic_interrupt_controller u_mic_interrupt_controller (.core_clk(core_clk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .ext_irq_pin(ext_irq_pin), .second_io_port_hi(second_io_port_hi),
      .timer_zero_rollover(timer_zero_rollover), .eeprom_write_done(eeprom_write_done),
      .cycle_boundary(cycle_boundary), .return_from_irq(return_from_irq),
      .sleep_active(sleep_active), .return_pc(return_pc), .irq_request(irq_request),
      .stack_push(stack_push), .stack_push_data(stack_push_data), .pc_load(pc_load),
      .pc_load_value(pc_load_value), .wake_up(wake_up));
   mic_core_model u_mic_core_model (.core_clk(core_clk), .reset(reset), .slow(slow),
      .irq_request(irq_request), .cycle_boundary(cycle_boundary), .return_pc(return_pc));
   // ---------------------------------------------------------------
   // Checking and bus tasks
   // ---------------------------------------------------------------
   task automatic summarize;
      $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [12:0] e, input logic [12:0] s);
      samples_checked++;
      if (s !== e) begin
         $display("Error %s expected %h seen %h", n, e, s);
         miscompares++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      chk("reg_rdata", {5'h00, e}, {5'h00, reg_rdata});
   endtask
   task automatic fire(input int s);
      @(posedge core_clk);
      case (s)
         0: second_io_port_hi <= ~second_io_port_hi;
         1: ext_irq_pin <= sel[BIT_EDGE_SEL];
         2: timer_zero_rollover <= 1'b1;
         default: eeprom_write_done <= 1'b1;
      endcase
      @(posedge core_clk);
      timer_zero_rollover <= 1'b0;
      eeprom_write_done <= 1'b0;
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      i = $urandom(38640);
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      rd(ADDR_IRQ_CONTROL, RESET_IRQ_CONTROL);
      rd(ADDR_EDGE_OPTION, RESET_EDGE_OPTION);
      wr(4'h9, 8'hff);
      rd(4'h9, 8'h00);
      // Sleeping with the global enable clear: flags, edges and wake-up.
      for (i = 0; i < 14; i++) begin
         src = (i < 4) ? i : $urandom % 4;
         en = $urandom;
         sel = (i == 1) ? 8'h00 : $urandom;
         @(posedge core_clk) ext_irq_pin <= ~sel[BIT_EDGE_SEL];
         wr(ADDR_EDGE_OPTION, sel);
         repeat (4) @(posedge core_clk);
         wr(ADDR_IRQ_CONTROL, en & 8'h78);
         wr(ADDR_EEPROM_CONTROL, 8'h00);
         fire(src);
         repeat (6) @(posedge core_clk);
         rd(ADDR_IRQ_CONTROL, (en & 8'h78) | (src < 3 ? 8'h01 << src : 8'h00));
         rd(ADDR_EEPROM_CONTROL, (src == 3) ? 8'h10 : 8'h00);
         chk("wake_up", {12'h000, en[src + 3] && src != 2}, {12'h000, wake_up});
         chk("irq_request", 13'h0000, {12'h000, irq_request});
      end
      // Awake, timer request taken with fast and slow instruction boundaries.
      @(posedge core_clk) sleep_active <= 1'b0;
      for (k = 0; k < 2; k++) begin
         @(posedge core_clk) slow <= k[0];
         wr(ADDR_IRQ_CONTROL, 8'ha0);
         fire(2);
         i = 0;
         while (pc_load !== 1'b1 && i < 60) begin
            @(posedge core_clk);
            #1;
            i++;
         end
         chk("pc_load", 13'h0001, {12'h000, pc_load});
         chk("stack_push", 13'h0001, {12'h000, stack_push});
         if (pc_load !== 1'b1) begin
            summarize();
         end
         chk("pc_load_value", IRQ_VECTOR, pc_load_value);
         chk("stack_push_data", return_pc, stack_push_data);
         repeat (4) @(posedge core_clk);
         rd(ADDR_IRQ_CONTROL, 8'h24);
         wr(ADDR_IRQ_CONTROL, 8'h20);
         @(posedge core_clk) return_from_irq <= 1'b1;
         @(posedge core_clk) return_from_irq <= 1'b0;
         rd(ADDR_IRQ_CONTROL, 8'ha0);
         chk("irq_request", 13'h0000, {12'h000, irq_request});
         chk("wake_up", 13'h0000, {12'h000, wake_up});
      end
      @(posedge core_clk) reset <= 1'b1;
      @(posedge core_clk) reset <= 1'b0;
      rd(ADDR_IRQ_CONTROL, RESET_IRQ_CONTROL);
      summarize();
   end
endmodule
